// >>> rtl/thv_pkg.sv
// Shared constants and types of the hub controller register and control block.
`default_nettype none
package thv_pkg;
  // ----------------------------------------------------------------
  // Bus qualification
  // ----------------------------------------------------------------
  localparam logic [5:0] THV_AM_DATA = 6'h39;
  localparam logic [5:0] THV_AM_PROG = 6'h3d;

  // ----------------------------------------------------------------
  // Register byte offsets inside the board window
  // ----------------------------------------------------------------
  localparam logic [3:0] THV_OFS_HUB_STATUS = 4'h0;
  localparam logic [3:0] THV_OFS_STORE_RECALL_SET = 4'h0;
  localparam logic [3:0] THV_OFS_STORE_RECALL_CLEAR = 4'h2;
  localparam logic [3:0] THV_OFS_CLOCK_GATE_SET = 4'h4;
  localparam logic [3:0] THV_OFS_CLOCK_GATE_CLEAR = 4'h6;
  localparam logic [3:0] THV_OFS_SIM_MODE_SET = 4'h8;
  localparam logic [3:0] THV_OFS_SIM_MODE_CLEAR = 4'ha;
  localparam logic [3:0] THV_OFS_SIM_START_STROBE = 4'hc;
  localparam logic [3:0] THV_OFS_INTERRUPT_LEVEL_SELECT = 4'he;
  localparam logic [19:0] THV_REG_TOP = 20'h0000e;
  localparam logic [19:0] THV_RAM_BASE = 20'h80000;
  localparam logic [19:0] THV_RAM_TOP = 20'h9fffc;
  localparam logic [19:0] THV_RESERVED_BASE = 20'ha0000;
  localparam logic [2:0] THV_RAM_MISSING_WORD = 3'h7;

  // ----------------------------------------------------------------
  // Register field positions, status reset value and missing-word data
  // ----------------------------------------------------------------
  localparam int THV_CLK_STEP_BIT = 0;
  localparam int THV_CLK_FANOUT_BIT = 1;
  localparam int THV_SIM_ENABLE_BIT = 0;
  localparam int THV_SIM_LOOP_BIT = 1;
  localparam int THV_STORE_BIT = 0;
  localparam int THV_RECALL_BIT = 1;
  localparam int THV_START_BIT = 0;
  localparam logic [15:0] THV_STATUS_RESET = 16'h00c0;
  localparam logic [15:0] THV_MISSING_DATA = 16'hffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int THV_CLK_PERIOD_NS = 25;
  localparam int THV_CLK_ERR_GAP_NS = 100;
  localparam int THV_CLK_GONE_GAP_NS = 1000;
  localparam logic [7:0] THV_CLK_ERR_CYC =
    8'((THV_CLK_ERR_GAP_NS + THV_CLK_PERIOD_NS - 1) / THV_CLK_PERIOD_NS);
  localparam logic [7:0] THV_CLK_GONE_CYC =
    8'((THV_CLK_GONE_GAP_NS + THV_CLK_PERIOD_NS - 1) / THV_CLK_PERIOD_NS);
  localparam logic [3:0] THV_SRAM_WAIT_CYC = 4'h4;
  localparam logic [11:0] THV_CTL_RESET = 12'h03f;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    THV_IDLE,
    THV_RAM_WAIT,
    THV_ACK,
    THV_RELEASE
  } thv_bus_st_t;
endpackage
`default_nettype wire

// >>> rtl/thv_hub_controller.sv
// Hub controller: bus slave, control registers, clock monitor, fanout multiplexer.
`default_nettype none
module thv_hub_controller
  import thv_pkg::*;
#(
  parameter int TRIG_WORDS = 6
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [23:1] vme_addr_in,
  input wire logic [5:0] vme_am_in,
  input wire logic vme_as_n_in,
  input wire logic vme_ds0_n_in,
  input wire logic vme_ds1_n_in,
  input wire logic vme_write_n_in,
  input wire logic vme_lword_n_in,
  input wire logic vme_iack_n_in,
  input wire logic [15:0] vme_data_in,
  output logic [15:0] vme_data_out,
  output logic vme_data_oe_out,
  output logic vme_dtack_oe_out,
  output logic [6:0] vme_irq_oe_out,
  input wire logic [3:0] base_switch_in,
  input wire logic irq_request_in,
  input wire logic init_ack_in,
  input wire logic link_sync_error_in,
  input wire logic bunch_sync_clock_in,
  input wire logic system_rf_clock_in,
  input wire logic external_step_clock_in,
  input wire logic [TRIG_WORDS*16-1:0] trig_data_in,
  input wire logic [15:0] sim_data_in,
  input wire logic sim_done_in,
  output logic [15:0] sram_addr_out,
  output logic [15:0] sram_wdata_out,
  input wire logic [15:0] sram_rdata_in,
  output logic sram_we_out,
  output logic sram_oe_out,
  output logic store_pulse_out,
  output logic recall_pulse_out,
  output logic sim_start_out,
  output logic sim_active_out,
  output logic step_clk_sel_out,
  output logic fanout_clk_out,
  output logic [15:0] fanout_data_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int TW = TRIG_WORDS * 16;

  typedef struct packed {
    logic [11:0] ctl_s1;
    logic [11:0] ctl_s2;
    logic [23:1] adr_s1;
    logic [23:1] adr_s2;
    logic [5:0] am_s1;
    logic [5:0] am_s2;
    logic [15:0] dat_s1;
    logic [15:0] dat_s2;
    logic [3:0] sw_s1;
    logic [3:0] sw_s2;
    logic [15:0] srd_s1;
    logic [15:0] srd_s2;
    logic [TW-1:0] trg_s1;
    logic [TW-1:0] trg_s2;
    logic bunch_sync_clock_d;
    logic rf_d;
    thv_bus_st_t st;
    logic [3:0] wait_cnt;
    logic wr;
    logic [1:0] clk_gate;
    logic [1:0] sim_mode;
    logic [2:0] irq_lvl;
    logic [7:0] gap_cnt;
    logic clk_err;
    logic clk_gone;
    logic sim_run;
    logic store_p;
    logic recall_p;
    logic start_p;
    logic step_sel;
    logic [TW-1:0] trig_lat;
    logic [3:0] word_idx;
    logic fanout_clk;
    logic [15:0] fanout_data;
    logic dtack_oe;
    logic [15:0] data_out;
    logic data_oe;
    logic [15:0] sram_addr;
    logic [15:0] sram_wdata;
    logic sram_we;
    logic sram_oe;
    logic [6:0] irq_oe;
  } thv_state_t;

  thv_state_t r_ff;
  thv_state_t nxt_r;

  // Synchronised pin aliases; only second stages are read by logic.
  logic as_n;
  logic ds0_n;
  logic ds1_n;
  logic write_n;
  logic lword_n;
  logic iack_n;
  logic bunch_sync_clock;
  logic rf;
  logic step;
  logic init_ack;
  logic sync_err;
  logic irq_req;
  logic [19:0] ofs;
  logic [15:0] status;

  assign {irq_req, sync_err, init_ack, step, rf, bunch_sync_clock, iack_n, lword_n, write_n, ds1_n, ds0_n, as_n} = r_ff.ctl_s2;
  assign ofs = {r_ff.adr_s2[19:1], 1'b0};
  // Live monitor and receiver bits sit beside the mirrored control bits.
  assign status = {5'h00, r_ff.irq_lvl, r_ff.clk_gone, r_ff.clk_err, sync_err, init_ack,
                   r_ff.sim_mode, r_ff.clk_gate};

  // ----------------------------------------------------------------
  // Address decoding helpers
  // ----------------------------------------------------------------
  function automatic logic in_ram(input logic [19:0] a);
    in_ram = (a >= THV_RAM_BASE) && (a < THV_RESERVED_BASE);
  endfunction

  function automatic logic in_regs(input logic [19:0] a);
    in_regs = (a <= THV_REG_TOP);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process holds every rule of the block so all state stays in one struct.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.store_p = 1'b0;
    nxt_r.recall_p = 1'b0;
    nxt_r.start_p = 1'b0;
    // Two-stage synchronisers for every pin-level input except the emulation data and done inputs.
    nxt_r.ctl_s1 = {irq_request_in, link_sync_error_in, init_ack_in, external_step_clock_in,
                    system_rf_clock_in, bunch_sync_clock_in, vme_iack_n_in, vme_lword_n_in,
                    vme_write_n_in, vme_ds1_n_in, vme_ds0_n_in, vme_as_n_in};
    nxt_r.ctl_s2 = r_ff.ctl_s1;
    nxt_r.adr_s1 = vme_addr_in;
    nxt_r.adr_s2 = r_ff.adr_s1;
    nxt_r.am_s1 = vme_am_in;
    nxt_r.am_s2 = r_ff.am_s1;
    nxt_r.dat_s1 = vme_data_in;
    nxt_r.dat_s2 = r_ff.dat_s1;
    nxt_r.sw_s1 = base_switch_in;
    nxt_r.sw_s2 = r_ff.sw_s1;
    nxt_r.srd_s1 = sram_rdata_in;
    nxt_r.srd_s2 = r_ff.srd_s1;
    nxt_r.trg_s1 = trig_data_in;
    nxt_r.trg_s2 = r_ff.trg_s1;
    nxt_r.bunch_sync_clock_d = bunch_sync_clock;
    nxt_r.rf_d = rf;

    // Trigger data is caught on the bunch sync edge, then sent word by word.
    if (bunch_sync_clock && !r_ff.bunch_sync_clock_d) begin
      nxt_r.trig_lat = r_ff.trg_s2;
    end
    if (rf && !r_ff.rf_d) begin
      nxt_r.word_idx = (r_ff.word_idx == 4'(TRIG_WORDS - 1)) ? 4'h0 : r_ff.word_idx + 4'h1;
      nxt_r.fanout_data = r_ff.sim_run ? sim_data_in : r_ff.trig_lat[int'(r_ff.word_idx) * 16 +: 16];
    end
    if (!r_ff.clk_gate[THV_CLK_FANOUT_BIT]) begin
      nxt_r.fanout_data = 16'h0000;
    end

    // Clock monitor: the gap counter saturates at the gone threshold.
    // The monitor input must tick slower than the core clock to be seen at all.
    if (rf && !r_ff.rf_d) begin
      nxt_r.gap_cnt = 8'h00;
    end else if (r_ff.gap_cnt < THV_CLK_GONE_CYC) begin
      nxt_r.gap_cnt = r_ff.gap_cnt + 8'h01;
    end
    nxt_r.clk_err = (r_ff.gap_cnt >= THV_CLK_ERR_CYC);
    nxt_r.clk_gone = (r_ff.gap_cnt >= THV_CLK_GONE_CYC);

    // Single-step source and fanout clock gating.
    nxt_r.step_sel = r_ff.clk_gate[THV_CLK_STEP_BIT] & r_ff.sim_mode[THV_SIM_ENABLE_BIT];
    nxt_r.fanout_clk = r_ff.clk_gate[THV_CLK_FANOUT_BIT] & (r_ff.step_sel ? step : bunch_sync_clock);

    // Emulation run: a finished run restarts itself while looping is set.
    if (sim_done_in && r_ff.sim_run) begin
      if (r_ff.sim_mode[THV_SIM_LOOP_BIT]) begin
        nxt_r.start_p = 1'b1;
      end else begin
        nxt_r.sim_run = 1'b0;
      end
    end

    // Interrupt line selection; level zero drives no line.
    nxt_r.irq_oe = 7'h00;
    if (irq_req && (r_ff.irq_lvl != 3'h0)) begin
      nxt_r.irq_oe[int'(r_ff.irq_lvl) - 1] = 1'b1;
    end

    // Bus slave.
    case (r_ff.st)
      THV_IDLE: begin
        nxt_r.dtack_oe = 1'b0;
        nxt_r.data_oe = 1'b0;
        if (!as_n && !ds0_n && !ds1_n && lword_n && iack_n &&
            (r_ff.am_s2 == THV_AM_DATA || r_ff.am_s2 == THV_AM_PROG) &&
            (r_ff.adr_s2[23:20] == r_ff.sw_s2)) begin
          nxt_r.wr = !write_n;
          nxt_r.st = THV_ACK;
          nxt_r.data_out = 16'h0000;
          if (in_ram(ofs)) begin
            if (ofs[3:1] == THV_RAM_MISSING_WORD) begin
              nxt_r.data_out = THV_MISSING_DATA;
            end else begin
              nxt_r.sram_addr = {ofs[16:4], ofs[3:1]};
              nxt_r.sram_wdata = r_ff.dat_s2;
              nxt_r.sram_we = !write_n;
              nxt_r.sram_oe = write_n;
              nxt_r.wait_cnt = THV_SRAM_WAIT_CYC;
              nxt_r.st = THV_RAM_WAIT;
            end
          end else if (!write_n && in_regs(ofs)) begin
            // Set and clear registers only touch the bits written as one.
            case (ofs[3:0])
              THV_OFS_STORE_RECALL_SET: begin
                nxt_r.store_p = r_ff.dat_s2[THV_STORE_BIT];
                nxt_r.recall_p = r_ff.dat_s2[THV_RECALL_BIT];
              end
              THV_OFS_CLOCK_GATE_SET: begin
                nxt_r.clk_gate = r_ff.clk_gate | r_ff.dat_s2[1:0];
              end
              THV_OFS_CLOCK_GATE_CLEAR: begin
                nxt_r.clk_gate = r_ff.clk_gate & ~r_ff.dat_s2[1:0];
              end
              THV_OFS_SIM_MODE_SET: begin
                nxt_r.sim_mode = r_ff.sim_mode | r_ff.dat_s2[1:0];
              end
              THV_OFS_SIM_MODE_CLEAR: begin
                nxt_r.sim_mode = r_ff.sim_mode & ~r_ff.dat_s2[1:0];
              end
              THV_OFS_SIM_START_STROBE: begin
                if (r_ff.dat_s2[THV_START_BIT] && r_ff.sim_mode[THV_SIM_ENABLE_BIT]) begin
                  nxt_r.start_p = 1'b1;
                  nxt_r.sim_run = 1'b1;
                end
              end
              THV_OFS_INTERRUPT_LEVEL_SELECT: begin
                nxt_r.irq_lvl = r_ff.dat_s2[2:0];
              end
              default: begin
                nxt_r.irq_lvl = r_ff.irq_lvl; // Clear of store/recall holds nothing.
              end
            endcase
          end else if (write_n && (ofs == 20'(THV_OFS_HUB_STATUS))) begin
            nxt_r.data_out = status;
          end
        end
      end
      THV_RAM_WAIT: begin
        if (r_ff.wait_cnt == 4'h0) begin
          nxt_r.data_out = r_ff.srd_s2;
          nxt_r.sram_we = 1'b0;
          nxt_r.sram_oe = 1'b0;
          nxt_r.st = THV_ACK;
        end else begin
          nxt_r.wait_cnt = r_ff.wait_cnt - 4'h1;
        end
      end
      THV_ACK: begin
        nxt_r.dtack_oe = 1'b1;
        nxt_r.data_oe = !r_ff.wr;
        nxt_r.st = THV_RELEASE;
      end
      THV_RELEASE: begin
        if (as_n) begin
          nxt_r.dtack_oe = 1'b0;
          nxt_r.data_oe = 1'b0;
          nxt_r.st = THV_IDLE;
        end
      end
      default: begin
        nxt_r.st = THV_IDLE;
      end
    endcase

    // A cleared emulation enable wins over any start, from the cycle after the clear write.
    if (!r_ff.sim_mode[THV_SIM_ENABLE_BIT]) begin
      nxt_r.sim_run = 1'b0;
      nxt_r.start_p = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Monitor flags start set because no system clock has been seen yet.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_ff <= '0;
      r_ff.ctl_s1 <= THV_CTL_RESET;
      r_ff.ctl_s2 <= THV_CTL_RESET;
      r_ff.st <= THV_IDLE;
      r_ff.gap_cnt <= THV_CLK_GONE_CYC;
      r_ff.clk_err <= THV_STATUS_RESET[6];
      r_ff.clk_gone <= THV_STATUS_RESET[7];
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from the state register
  // ----------------------------------------------------------------
  assign vme_data_out = r_ff.data_out;
  assign vme_data_oe_out = r_ff.data_oe;
  assign vme_dtack_oe_out = r_ff.dtack_oe;
  assign vme_irq_oe_out = r_ff.irq_oe;
  assign sram_addr_out = r_ff.sram_addr;
  assign sram_wdata_out = r_ff.sram_wdata;
  assign sram_we_out = r_ff.sram_we;
  assign sram_oe_out = r_ff.sram_oe;
  assign store_pulse_out = r_ff.store_p;
  assign recall_pulse_out = r_ff.recall_p;
  assign sim_start_out = r_ff.start_p;
  assign sim_active_out = r_ff.sim_run;
  assign step_clk_sel_out = r_ff.step_sel;
  assign fanout_clk_out = r_ff.fanout_clk;
  assign fanout_data_out = r_ff.fanout_data;
endmodule
`default_nettype wire

// >>> verif/thv_hub_chk.sv
// Concurrent checks on the port behaviour of the hub controller.
`default_nettype none
module thv_hub_chk (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [23:1] vme_addr_in,
  input wire logic [5:0] vme_am_in,
  input wire logic vme_as_n_in,
  input wire logic vme_write_n_in,
  input wire logic [3:0] base_switch_in,
  input wire logic vme_data_oe_out,
  input wire logic vme_dtack_oe_out,
  input wire logic [6:0] vme_irq_oe_out,
  input wire logic sram_we_out,
  input wire logic store_pulse_out,
  input wire logic recall_pulse_out,
  input wire logic sim_start_out,
  input wire logic sim_active_out
);
  // Pins pass two synchroniser stages, so every answer lags its cause by several cycles.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_ack_settled: assert property ($rose(vme_dtack_oe_out) |-> !vme_as_n_in && !$past(vme_as_n_in, 3))
    else $error("acknowledge without a settled strobe");
  a_am_accepted: assert property ($rose(vme_dtack_oe_out) |-> vme_am_in == 6'h39 || vme_am_in == 6'h3d)
    else $error("acknowledge for a foreign modifier");
  a_board_match: assert property ($rose(vme_dtack_oe_out) |-> vme_addr_in[23:20] == base_switch_in)
    else $error("acknowledge for another board");
  a_store_cause: assert property (store_pulse_out |->
    (!vme_write_n_in && vme_addr_in[19:1] == 19'h0) ##1 !store_pulse_out) else $error("stray store pulse");
  a_recall_cause: assert property (recall_pulse_out |->
    (!vme_write_n_in && vme_addr_in[19:1] == 19'h0) ##1 !recall_pulse_out) else $error("stray recall pulse");
  a_run_start: assert property ($rose(sim_active_out) |->
    sim_start_out && !vme_write_n_in && vme_addr_in[19:1] == 19'h6) else $error("run began without a start write");
  a_irq_single: assert property ($onehot0(vme_irq_oe_out))
    else $error("more than one interrupt line driven");
  a_read_drive: assert property (vme_data_oe_out |-> vme_dtack_oe_out && vme_write_n_in)
    else $error("data driven outside a read answer");
  a_ack_release: assert property (vme_as_n_in [*6] |-> !vme_dtack_oe_out && !vme_data_oe_out)
    else $error("answer held after strobe release");
  a_ram_wait: assert property ($rose(vme_dtack_oe_out) && vme_addr_in[19:17] == 3'b100 &&
    vme_addr_in[3:1] != 3'h7 |-> !$past(vme_as_n_in, 8)) else $error("memory answer came too early");
  a_sram_write: assert property (sram_we_out |-> !vme_write_n_in && !vme_as_n_in)
    else $error("memory written outside a write cycle");
endmodule

bind thv_hub_controller thv_hub_chk thv_hub_chk_inst (.core_clk_in, .reset_n_in, .vme_addr_in, .vme_am_in,
  .vme_as_n_in, .vme_write_n_in, .base_switch_in, .vme_data_oe_out, .vme_dtack_oe_out, .vme_irq_oe_out,
  .sram_we_out, .store_pulse_out, .recall_pulse_out, .sim_start_out, .sim_active_out);
`default_nettype wire

// >>> verif/thv_vme_master.sv
// Bus master model that runs single word cycles against the hub.
`default_nettype none
module thv_vme_master (
  input wire logic clk_in,
  input wire logic dtack_oe_in,
  input wire logic [15:0] rdata_in,
  output logic [23:1] addr_out,
  output logic [5:0] am_out,
  output logic as_n_out,
  output logic ds_n_out,
  output logic write_n_out,
  output logic [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Extra periods the strobes stay low after the answer, to act as a slow master.
  int hold = 0;

  // Idle bus with strobes released.
  initial begin
    addr_out = '0;
    am_out = '0;
    as_n_out = 1'b1;
    ds_n_out = 1'b1;
    write_n_out = 1'b1;
    wdata_out = '0;
  end

  // Both data strobes, held until the answer; the lines are scrambled on release so nothing stale lingers.
  task automatic cycle(input logic [23:0] a, input logic [5:0] am, input logic wr, input logic [15:0] wd,
      output logic [15:0] rd, output logic ok);
    int n;
    @(posedge clk_in);
    #1;
    addr_out = a[23:1];
    am_out = am;
    write_n_out = !wr;
    wdata_out = wd;
    as_n_out = 1'b0;
    ds_n_out = 1'b0;
    n = 0;
    // The answer and its data are taken at the edge itself, so the request still stands when it is seen.
    do begin
      @(posedge clk_in);
      n++;
    end while (dtack_oe_in !== 1'b1 && n < 40);
    ok = dtack_oe_in;
    rd = rdata_in;
    repeat (hold) @(posedge clk_in);
    #1;
    as_n_out = 1'b1;
    ds_n_out = 1'b1;
    addr_out = ~addr_out;
    am_out = ~am_out;
    wdata_out = ~wdata_out;
    n = 0;
    while (dtack_oe_in === 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    // Return off the edge so callers never change inputs in the time step of a clock edge.
    #1;
  endtask
endmodule
`default_nettype wire

// >>> verif/thv_hub_controller_tb.sv
// Self-checking testbench of the hub controller register and control block.
`default_nettype none
module thv_hub_controller_tb
  import thv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in = 1'b0, reset_n_in = 1'b0, bunch_sync_clock_in = 1'b0, system_rf_clock_in = 1'b0;
  logic rf_run = 1'b0, init_ack_in = 1'b0, link_sync_error_in = 1'b0, irq_request_in = 1'b0, sim_done_in = 1'b0;
  logic [3:0] base_switch_in = 4'h8;
  logic [23:1] vme_addr_in;
  logic [5:0] vme_am_in;
  logic vme_as_n_in, vme_ds_n, vme_write_n_in, vme_data_oe_out, vme_dtack_oe_out, sram_we_out, sram_oe_out;
  logic store_pulse_out, recall_pulse_out, sim_start_out, sim_active_out, step_clk_sel_out, fanout_clk_out;
  logic [15:0] vme_data_in, vme_data_out, sram_addr_out, sram_wdata_out, fanout_data_out;
  logic [15:0] sram_rdata_in = 16'h0;
  logic [15:0] sim_data_in = 16'h0;
  logic vme_lword_n_in = 1'b1, vme_iack_n_in = 1'b1;
  logic [6:0] vme_irq_oe_out;
  logic [15:0] mem [0:65535];
  int fails = 0, n_tests = 0, n_store = 0, n_recall = 0, n_start = 0, n_fan = 0, cycles = 0;

  thv_hub_controller #(.TRIG_WORDS(6)) thv_hub_controller_inst (.core_clk_in, .reset_n_in, .vme_addr_in,
    .vme_am_in, .vme_as_n_in, .vme_ds0_n_in(vme_ds_n), .vme_ds1_n_in(vme_ds_n), .vme_write_n_in,
    .vme_lword_n_in, .vme_iack_n_in, .vme_data_in, .vme_data_out, .vme_data_oe_out, .vme_dtack_oe_out,
    .vme_irq_oe_out, .base_switch_in, .irq_request_in, .init_ack_in, .link_sync_error_in, .bunch_sync_clock_in,
    .system_rf_clock_in, .external_step_clock_in(1'b0), .trig_data_in(96'h0), .sim_data_in, .sim_done_in,
    .sram_addr_out, .sram_wdata_out, .sram_rdata_in, .sram_we_out, .sram_oe_out, .store_pulse_out,
    .recall_pulse_out, .sim_start_out, .sim_active_out, .step_clk_sel_out, .fanout_clk_out, .fanout_data_out);
  thv_vme_master thv_vme_master_inst (.clk_in(core_clk_in), .dtack_oe_in(vme_dtack_oe_out),
    .rdata_in(vme_data_out), .addr_out(vme_addr_in), .am_out(vme_am_in), .as_n_out(vme_as_n_in),
    .ds_n_out(vme_ds_n), .write_n_out(vme_write_n_in), .wdata_out(vme_data_in));

  // Core clock, bunch sync near 7.6 MHz, and a system clock that can be stopped to upset the monitor.
  always #12.5 core_clk_in = ~core_clk_in;
  always #66 bunch_sync_clock_in = ~bunch_sync_clock_in;
  always #30 if (rf_run) system_rf_clock_in = ~system_rf_clock_in;

  // Static memory; with output enable low it shows a changing pattern rather than stale data.
  always @(posedge core_clk_in) begin
    if (sram_we_out) mem[sram_addr_out] <= sram_wdata_out;
    sram_rdata_in <= sram_oe_out ? mem[sram_addr_out] : ~sram_rdata_in;
  end

  // Pulse counters sampled mid-cycle, away from the launching edge, plus the hang guard.
  always @(negedge core_clk_in) begin
    n_store += int'(store_pulse_out);
    n_recall += int'(recall_pulse_out);
    n_start += int'(sim_start_out);
    n_fan += int'(fanout_clk_out);
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(input logic [19:0] ofs, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    thv_vme_master_inst.cycle({base_switch_in, ofs}, THV_AM_DATA, 1'b1, d, r, ok);
    check("write ack", 16'(ok), 16'h1);
  endtask

  task automatic rd(input logic [19:0] ofs, input logic [15:0] exp, input string what);
    logic [15:0] r;
    logic ok;
    thv_vme_master_inst.cycle({base_switch_in, ofs}, THV_AM_PROG, 1'b0, 16'h0, r, ok);
    check("read ack", 16'(ok), 16'h1);
    check(what, r, exp);
  endtask

  task automatic done;
    sim_done_in = 1'b1;
    tick(1);
    sim_done_in = 1'b0;
    tick(2);
  endtask

  task automatic t_monitor;
    rf_run = 1'b1;
    tick(20);
    rd(20'h0, 16'h0000, "status clock good");
    rf_run = 1'b0;
    tick(6);
    rd(20'h0, 16'h0040, "status clock error");
    tick(40);
    rd(20'h0, 16'h00c0, "status clock gone");
    rf_run = 1'b1;
    tick(20);
    init_ack_in = 1'b1;
    link_sync_error_in = 1'b1;
    tick(4);
    rd(20'h0, 16'h0030, "status live bits");
    init_ack_in = 1'b0;
    link_sync_error_in = 1'b0;
    tick(4);
  endtask

  task automatic t_gate;
    int f;
    f = n_fan;
    tick(30);
    check("fanout clock gated", 16'(n_fan - f), 16'h0);
    wr(20'h4, 16'h000f);
    rd(20'h0, 16'h0003, "clock bits set");
    wr(20'h6, 16'h0001);
    rd(20'h0, 16'h0002, "clock bit cleared");
    f = n_fan;
    tick(30);
    check("fanout clock runs", 16'(n_fan > f), 16'h1);
  endtask

  task automatic t_strobes;
    int s;
    int r;
    s = n_store;
    r = n_recall;
    wr(20'h0, 16'h0001);
    check("store pulses", 16'(n_store - s), 16'h1);
    check("recall idle", 16'(n_recall - r), 16'h0);
    wr(20'h0, 16'h0002);
    check("recall pulses", 16'(n_recall - r), 16'h1);
    rd(20'h0, 16'h0002, "status hides strobes");
  endtask

  task automatic t_sim;
    int s;
    s = n_start;
    wr(20'hc, 16'h0001);
    wr(20'h4, 16'h0001);
    check("start without enable", 16'(n_start - s), 16'h0);
    check("step without enable", 16'(step_clk_sel_out), 16'h0);
    wr(20'h8, 16'h0001);
    check("step with enable", 16'(step_clk_sel_out), 16'h1);
    rd(20'h0, 16'h0007, "emulation status");
    sim_data_in = 16'h5a5a;
    wr(20'hc, 16'h0001);
    check("start pulse", 16'(n_start - s), 16'h1);
    check("run active", 16'(sim_active_out), 16'h1);
    tick(6);
    check("fanout emulation data", fanout_data_out, 16'h5a5a);
    done();
    check("run ends", 16'(sim_active_out), 16'h0);
    wr(20'h8, 16'h0002);
    wr(20'hc, 16'h0001);
    done();
    check("loop restart", 16'(n_start - s), 16'h3);
    wr(20'ha, 16'h0002);
    done();
    check("loop stopped", 16'(sim_active_out), 16'h0);
    wr(20'ha, 16'h0001);
    check("step after disable", 16'(step_clk_sel_out), 16'h0);
    wr(20'h6, 16'h0001);
  endtask

  task automatic t_irq;
    irq_request_in = 1'b1;
    for (int l = 1; l < 8; l++) begin
      wr(20'he, 16'(l));
      tick(4);
      check("irq line", 16'(vme_irq_oe_out), 16'(1 << (l - 1)));
      rd(20'h0, 16'(l << 8) | 16'h0002, "irq level");
    end
    // Level zero is left behind so later status reads see a clean level field.
    wr(20'he, 16'h0000);
    tick(4);
    check("irq level zero", 16'(vme_irq_oe_out), 16'h0000);
    irq_request_in = 1'b0;
  endtask

  task automatic t_refuse;
    logic [15:0] d;
    logic ok;
    thv_vme_master_inst.cycle({base_switch_in, 20'h4}, 6'h29, 1'b1, 16'h0001, d, ok);
    check("foreign modifier ack", 16'(ok), 16'h0);
    thv_vme_master_inst.cycle({~base_switch_in, 20'h4}, THV_AM_DATA, 1'b1, 16'h0001, d, ok);
    check("foreign board ack", 16'(ok), 16'h0);
    vme_iack_n_in = 1'b0;
    thv_vme_master_inst.cycle({base_switch_in, 20'h4}, THV_AM_DATA, 1'b1, 16'h0001, d, ok);
    check("interrupt cycle ack", 16'(ok), 16'h0);
    vme_iack_n_in = 1'b1;
    vme_lword_n_in = 1'b0;
    thv_vme_master_inst.cycle({base_switch_in, 20'h4}, THV_AM_DATA, 1'b1, 16'h0001, d, ok);
    check("long word ack", 16'(ok), 16'h0);
    vme_lword_n_in = 1'b1;
    wr(20'h10, 16'hffff);
    rd(20'h10, 16'h0000, "reserved read");
    rd(20'h4, 16'h0000, "write-only read");
    rd(20'h0, 16'h0002, "status unchanged");
  endtask

  task automatic t_ram;
    thv_vme_master_inst.hold = 4;
    wr(20'h80010, 16'h1234);
    wr(20'h9fffc, 16'h5a0f);
    rd(20'h80010, 16'h1234, "ram word");
    rd(20'h9fffc, 16'h5a0f, "ram top word");
    rd(20'h8001e, THV_MISSING_DATA, "missing ram word");
    rd(20'ha0000, 16'h0000, "above ram");
    thv_vme_master_inst.hold = 0;
  endtask

  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    tick(4);
    rd(20'h0, THV_STATUS_RESET, "status after reset");
    t_monitor();
    t_gate();
    t_strobes();
    t_sim();
    t_irq();
    t_refuse();
    t_ram();
    summarize();
  end
endmodule
`default_nettype wire
